/* design/hpc_pkg.sv */
`default_nettype none
package hpc_pkg;
  // access-select encoding, bit 1 is the msb
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDRESS = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int BUF_DEPTH = 2;

  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
  localparam int CTRL_INT_BIT = 1;

  typedef enum logic [1:0] {
    HPC_IDLE = 2'b00,
    HPC_ACTIVE = 2'b01,
    HPC_DONE = 2'b10
  } hpc_state_e;

  // one host access, as captured at the leading strobe edge
  typedef struct packed {
    logic [1:0] target;
    logic rd;
    logic byte_order;
    logic [DATA_W-1:0] wdata;
  } hpc_req_s;
endpackage : hpc_pkg
`default_nettype wire

/* design/hpc_buf.sv */
`default_nettype none
module hpc_buf (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  output logic o_ready,
  input wire hpc_pkg::hpc_req_s i_data,
  output logic o_valid,
  input wire logic i_ready,
  output hpc_pkg::hpc_req_s o_data
);
  hpc_pkg::hpc_req_s mem_q [hpc_pkg::BUF_DEPTH];
  hpc_pkg::hpc_req_s mem_d [hpc_pkg::BUF_DEPTH];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data = mem_q[rp_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = i_data;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < hpc_pkg::BUF_DEPTH; k++) begin
        mem_q[k] <= '0;
      end
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (i_ce) begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // hpc_buf
`default_nettype wire

/* design/hpc_top.sv */
// What this block does
// - the two access-select inputs together pick the control register, data with autoincrement, address, or data.
// - after reset the select and direction pins are inputs only and are never driven.
// - host accesses count only while port_select_n is low; strobes are ignored otherwise.
// - the read_write_select level marks each access as read or write and the port acts in that direction.
// - the two data strobes time each transfer, capturing write data and presenting read data.
// - port_ready_out tells the host when the next transfer may start.
// - port_ready_out floats during reset and is driven 1 once reset ends.
// - host_interrupt_out floats during reset and is driven 1 once reset ends.
// - with port_enable_in low data strobes are ignored and every port output floats; the address-latch strobe still loads the address register.
// - in multiplexed mode the address-latch strobe loads the address register; it does nothing otherwise.
`default_nettype none
module hpc_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_port_enable_in,
  input wire logic i_mux_mode,
  input wire logic i_access_select_bit0,
  input wire logic i_access_select_bit1,
  input wire logic i_port_select_n,
  input wire logic i_read_write_select,
  input wire logic i_data_strobe_a_n,
  input wire logic i_data_strobe_b_n,
  input wire logic i_address_latch_strobe_n,
  input wire logic i_byte_order_select,
  input wire logic [hpc_pkg::DATA_W-1:0] i_hd,
  output logic [hpc_pkg::DATA_W-1:0] o_hd,
  output logic o_hd_oe_n,
  output logic o_port_ready_out,
  output logic o_port_ready_oe_n,
  output logic o_host_interrupt_out,
  output logic o_host_interrupt_oe_n,
  input wire logic i_dev_int_set
);
  hpc_pkg::hpc_state_e st_q, st_d;
  logic stb_q, stb_d, als_q, als_d;
  logic [hpc_pkg::DATA_W-1:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
  logic [hpc_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [hpc_pkg::DATA_W-1:0] mem_q [hpc_pkg::MEM_DEPTH];
  logic [hpc_pkg::DATA_W-1:0] mem_wdata;
  logic mem_we;
  logic rd_drive_q, rd_drive_d;
  logic stb, stb_rise, stb_fall, als_fall;
  logic req_valid, req_ready, exe_valid, exe_ready;
  hpc_pkg::hpc_req_s req, exe;
  logic [1:0] sel;

  assign sel = {i_access_select_bit1, i_access_select_bit0};
  assign stb = !i_data_strobe_a_n || !i_data_strobe_b_n;
  assign stb_fall = stb && !stb_q && !i_port_select_n && i_port_enable_in;
  assign stb_rise = !stb && stb_q;
  assign als_fall = !i_address_latch_strobe_n && als_q && i_mux_mode && !i_port_select_n;

  assign req.target = sel;
  assign req.rd = i_read_write_select;
  assign req.byte_order = i_byte_order_select;
  assign req.wdata = i_hd;
  assign req_valid = stb_fall && (st_q == hpc_pkg::HPC_IDLE);

  // two-entry queue hands each captured access to the register side, which is always ready (exe_ready is 1) and takes it the next cycle
  hpc_buf u_buf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(req_valid),
    .o_ready(req_ready),
    .i_data(req),
    .o_valid(exe_valid),
    .i_ready(exe_ready),
    .o_data(exe)
  );
  assign exe_ready = 1'b1;

  always_comb begin
    st_d = st_q;
    case (st_q)
      hpc_pkg::HPC_IDLE: begin
        if (req_valid && req_ready) begin
          st_d = hpc_pkg::HPC_ACTIVE;
        end
      end
      hpc_pkg::HPC_ACTIVE: begin
        if (stb_rise || i_port_select_n) begin
          st_d = hpc_pkg::HPC_DONE;
        end
      end
      hpc_pkg::HPC_DONE: begin
        if (!exe_valid) begin
          st_d = hpc_pkg::HPC_IDLE;
        end
      end
      default: begin
        st_d = hpc_pkg::HPC_IDLE;
      end
    endcase
    if (!i_port_enable_in) begin
      st_d = hpc_pkg::HPC_IDLE;
    end
  end

  always_comb begin
    stb_d = stb;
    als_d = i_address_latch_strobe_n;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    rdata_d = rdata_q;
    mem_we = 1'b0;
    mem_wdata = exe.wdata;
    rd_drive_d = rd_drive_q;
    if (als_fall) begin
      addr_d = i_hd[hpc_pkg::ADDR_W-1:0];
    end
    if (exe_valid) begin
      case (exe.target)
        hpc_pkg::SEL_CONTROL: begin
          if (exe.rd) begin
            rdata_d = ctrl_q;
          end else begin
            ctrl_d = exe.wdata;
          end
        end
        hpc_pkg::SEL_ADDRESS: begin
          if (exe.rd) begin
            rdata_d = {{(hpc_pkg::DATA_W-hpc_pkg::ADDR_W){1'b0}}, addr_q};
          end else begin
            addr_d = exe.wdata[hpc_pkg::ADDR_W-1:0];
          end
        end
        hpc_pkg::SEL_DATA_INC, hpc_pkg::SEL_DATA: begin
          if (exe.rd) begin
            rdata_d = mem_q[addr_q];
          end else begin
            mem_we = 1'b1;
          end
          if (exe.target == hpc_pkg::SEL_DATA_INC) begin
            addr_d = addr_q + hpc_pkg::ADDR_STEP;
          end
        end
        default: begin
          rdata_d = rdata_q;
        end
      endcase
    end
    // set from the device side wins over a host clear in the same cycle
    if (i_dev_int_set) begin
      ctrl_d[hpc_pkg::CTRL_INT_BIT] = 1'b1;
    end
    if (req_valid && req_ready) begin
      rd_drive_d = i_read_write_select;
    end else if (((st_q == hpc_pkg::HPC_DONE) && !exe_valid) || !i_port_enable_in) begin
      // read data stays driven through DONE, the cycle after strobe release in which the host takes it
      rd_drive_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= hpc_pkg::HPC_IDLE;
      stb_q <= 1'b0;
      als_q <= 1'b1;
      ctrl_q <= hpc_pkg::CTRL_RESET;
      addr_q <= hpc_pkg::ADDR_RESET;
      rdata_q <= '0;
      rd_drive_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      stb_q <= stb_d;
      als_q <= als_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      rdata_q <= rdata_d;
      rd_drive_q <= rd_drive_d;
    end
  end

  // the array has no reset: it is a plain memory the host fills
  always_ff @(posedge i_mclk) begin
    if (i_ce && mem_we) begin
      mem_q[addr_q] <= mem_wdata;
    end
  end

  // output drivers: reset and disable both float the pins
  assign o_hd = rdata_q;
  assign o_hd_oe_n = !(rd_drive_q && (st_q == hpc_pkg::HPC_DONE) && !exe_valid) || i_rst || i_port_select_n
    || !i_port_enable_in;
  assign o_port_ready_out = (st_q == hpc_pkg::HPC_IDLE) && req_ready;
  assign o_port_ready_oe_n = i_rst || !i_port_enable_in;
  // line is active low: a set interrupt bit pulls it to 0
  assign o_host_interrupt_out = !ctrl_q[hpc_pkg::CTRL_INT_BIT];
  assign o_host_interrupt_oe_n = i_rst || !i_port_enable_in;

  property p_ready_float_in_reset;
    @(posedge i_mclk) i_rst |-> o_port_ready_oe_n && o_host_interrupt_oe_n;
  endproperty
  a_ready_float_in_reset: assert property (p_ready_float_in_reset) else $error("outputs driven in reset");

  property p_int_high_after_reset;
    @(posedge i_mclk) $fell(i_rst) && i_port_enable_in |-> o_host_interrupt_out && !o_host_interrupt_oe_n;
  endproperty
  a_int_high_after_reset: assert property (p_int_high_after_reset) else $error("interrupt not 1 after reset");

  property p_disable_floats;
    @(posedge i_mclk) disable iff (i_rst) !i_port_enable_in |-> o_port_ready_oe_n && o_hd_oe_n && o_host_interrupt_oe_n;
  endproperty
  a_disable_floats: assert property (p_disable_floats) else $error("output driven while disabled");

  property p_unselected_ignored;
    @(posedge i_mclk) disable iff (i_rst) i_port_select_n |-> !req_valid;
  endproperty
  a_unselected_ignored: assert property (p_unselected_ignored) else $error("strobe taken while unselected");

  sequence s_take;
    i_ce && req_valid && req_ready;
  endsequence
  property p_busy_after_take;
    @(posedge i_mclk) disable iff (i_rst) s_take ##1 1'b1 |-> !o_port_ready_out;
  endproperty
  a_busy_after_take: assert property (p_busy_after_take) else $error("ready during access");

  property p_autoinc;
    @(posedge i_mclk) disable iff (i_rst)
      i_ce && exe_valid && exe.target == hpc_pkg::SEL_DATA_INC && !als_fall |=> addr_q == $past(addr_q) + hpc_pkg::ADDR_STEP;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("address not incremented");

  property p_no_inc;
    @(posedge i_mclk) disable iff (i_rst)
      i_ce && exe_valid && exe.target == hpc_pkg::SEL_DATA && !als_fall |=> addr_q == $past(addr_q);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("address moved on plain data access");

  property p_ctrl_write;
    @(posedge i_mclk) disable iff (i_rst)
      i_ce && exe_valid && exe.target == hpc_pkg::SEL_CONTROL && !exe.rd && !i_dev_int_set |=> ctrl_q == $past(exe.wdata);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_strobe_combined;
    @(posedge i_mclk) disable iff (i_rst)
      i_ce && i_port_enable_in && !i_port_select_n && st_q == hpc_pkg::HPC_IDLE && !stb_q && !i_data_strobe_b_n
      |-> req_valid;
  endproperty
  a_strobe_combined: assert property (p_strobe_combined) else $error("second strobe not combined");
endmodule // hpc_top
`default_nettype wire

/* sim/hpc_host.sv */
`default_nettype none
module hpc_host (
  input wire logic i_mclk,
  input wire logic i_ready,
  input wire logic [hpc_pkg::DATA_W-1:0] i_rd,
  input wire logic i_rd_oe_n,
  output logic o_sel0,
  output logic o_sel1,
  output logic o_cs_n,
  output logic o_rw,
  output logic o_ds_a_n,
  output logic o_ds_b_n,
  output logic o_als_n,
  output logic o_bos,
  output logic [hpc_pkg::DATA_W-1:0] o_wd
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle until the bench calls a task, so nothing is requested during reset
  initial begin
    {o_sel1, o_sel0, o_rw, o_bos} = 4'h0;
    {o_cs_n, o_ds_a_n, o_ds_b_n, o_als_n} = 4'hF;
    o_wd = 16'h0000;
  end
  task automatic xfer(input logic [1:0] sel, input logic rd, input logic [15:0] wd, input logic cs_n,
                      input logic use_b, output logic [15:0] rdat, output logic ok);
    int n;
    ok = 1'b1;
    rdat = 16'h0000;
    @(posedge i_mclk);
    {o_sel1, o_sel0} <= sel;
    o_rw <= rd;
    o_cs_n <= cs_n;
    o_bos <= 1'b0;
    o_wd <= wd;
    if (use_b) o_ds_b_n <= 1'b0; else o_ds_a_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    o_ds_a_n <= 1'b1;
    o_ds_b_n <= 1'b1;
    if (rd) begin
      for (n = 0; n < 8 && i_rd_oe_n !== 1'b0; n++) @(posedge i_mclk);
      if (n == 8) ok = 1'b0;
      rdat = i_rd;
    end
    for (n = 0; n < 20 && i_ready !== 1'b1; n++) @(posedge i_mclk);
    if (n == 20) ok = 1'b0;
    o_cs_n <= 1'b1;
    // released data lines must not keep showing the last word
    o_wd <= ~wd;
  endtask
  task automatic latch_addr(input logic [7:0] a);
    @(posedge i_mclk);
    o_cs_n <= 1'b0;
    o_wd <= {8'h00, a};
    o_als_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    o_als_n <= 1'b1;
    o_cs_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule // hpc_host
`default_nettype wire

/* sim/hpc_top_test.sv */
`default_nettype none
module hpc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_rst, i_ce, i_port_enable_in, i_mux_mode, i_dev_int_set;
  logic i_access_select_bit0, i_access_select_bit1, i_port_select_n, i_read_write_select;
  logic i_data_strobe_a_n, i_data_strobe_b_n, i_address_latch_strobe_n, i_byte_order_select;
  logic [15:0] i_hd, o_hd;
  logic o_hd_oe_n, o_port_ready_out, o_port_ready_oe_n, o_host_interrupt_out, o_host_interrupt_oe_n;
  int bad_count, n_checks;
  hpc_top hpc_top_inst (.i_mclk, .i_rst, .i_ce, .i_port_enable_in, .i_mux_mode, .i_access_select_bit0,
    .i_access_select_bit1, .i_port_select_n, .i_read_write_select, .i_data_strobe_a_n, .i_data_strobe_b_n,
    .i_address_latch_strobe_n, .i_byte_order_select, .i_hd, .o_hd, .o_hd_oe_n, .o_port_ready_out,
    .o_port_ready_oe_n, .o_host_interrupt_out, .o_host_interrupt_oe_n, .i_dev_int_set);
  // a floated line shows the inverse of what the design leaves on it, so a host ignoring enables sees junk
  hpc_host hpc_host_inst (.i_mclk(i_mclk), .i_ready(o_port_ready_oe_n ? ~o_port_ready_out : o_port_ready_out),
    .i_rd(o_hd_oe_n ? ~o_hd : o_hd), .i_rd_oe_n(o_hd_oe_n),
    .o_sel0(i_access_select_bit0), .o_sel1(i_access_select_bit1), .o_cs_n(i_port_select_n),
    .o_rw(i_read_write_select), .o_ds_a_n(i_data_strobe_a_n), .o_ds_b_n(i_data_strobe_b_n),
    .o_als_n(i_address_latch_strobe_n), .o_bos(i_byte_order_select), .o_wd(i_hd));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [15:0] d, input logic cs = 1'b0);
    logic [15:0] r;
    logic ok;
    hpc_host_inst.xfer(s, 1'b0, d, cs, 1'b0, r, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic rdc(input logic [1:0] s, input logic [15:0] e, input logic b = 1'b0);
    logic [15:0] r;
    logic ok;
    hpc_host_inst.xfer(s, 1'b1, 16'h0000, 1'b0, b, r, ok);
    chk(16'(ok), 16'h0001);
    chk(r, e);
  endtask
  task automatic t_reset();
    chk({o_hd_oe_n, o_port_ready_oe_n, o_host_interrupt_oe_n}, 16'h0007);
    repeat (4) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({o_port_ready_oe_n, o_port_ready_out, o_host_interrupt_oe_n, o_host_interrupt_out}, 16'h0005);
  endtask
  task automatic t_regs();
    wr(hpc_pkg::SEL_ADDRESS, 16'h0010);
    fork
      wr(hpc_pkg::SEL_DATA_INC, 16'hA5A5);
      begin repeat (3) @(posedge i_mclk); chk(16'(o_port_ready_out), 16'h0000); end
    join
    wr(hpc_pkg::SEL_DATA_INC, 16'h5A5A);
    rdc(hpc_pkg::SEL_ADDRESS, 16'h0012);
    wr(hpc_pkg::SEL_ADDRESS, 16'h0010);
    rdc(hpc_pkg::SEL_DATA_INC, 16'hA5A5, 1'b1);
    rdc(hpc_pkg::SEL_DATA_INC, 16'h5A5A);
    wr(hpc_pkg::SEL_ADDRESS, 16'h0010);
    rdc(hpc_pkg::SEL_DATA, 16'hA5A5);
    rdc(hpc_pkg::SEL_DATA, 16'hA5A5);
  endtask
  task automatic t_ignored();
    logic [15:0] r;
    logic ok;
    wr(hpc_pkg::SEL_DATA, 16'hFFFF, 1'b1);
    rdc(hpc_pkg::SEL_DATA, 16'hA5A5);
    @(posedge i_mclk);
    i_port_enable_in <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({o_hd_oe_n, o_port_ready_oe_n, o_host_interrupt_oe_n}, 16'h0007);
    hpc_host_inst.xfer(hpc_pkg::SEL_DATA, 1'b0, 16'h1234, 1'b0, 1'b0, r, ok);
    i_port_enable_in <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rdc(hpc_pkg::SEL_DATA, 16'hA5A5);
  endtask
  task automatic t_int();
    @(posedge i_mclk);
    i_dev_int_set <= 1'b1;
    @(posedge i_mclk);
    i_dev_int_set <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk(16'(o_host_interrupt_out), 16'h0000);
    rdc(hpc_pkg::SEL_CONTROL, 16'h0001 << hpc_pkg::CTRL_INT_BIT);
    wr(hpc_pkg::SEL_CONTROL, 16'h0000);
    repeat (2) @(posedge i_mclk);
    chk(16'(o_host_interrupt_out), 16'h0001);
  endtask
  task automatic t_mux();
    @(posedge i_mclk);
    i_mux_mode <= 1'b1;
    hpc_host_inst.latch_addr(8'h11);
    rdc(hpc_pkg::SEL_DATA, 16'h5A5A);
    i_mux_mode <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    bad_count = 0;
    n_checks = 0;
    {i_rst, i_ce, i_port_enable_in, i_mux_mode, i_dev_int_set} = 5'h1C;
    #1;
    t_reset();
    t_regs();
    t_ignored();
    t_int();
    t_mux();
    print_verdict();
  end
endmodule // hpc_top_test
`default_nettype wire
